// File: nsf_map.svh
// constants of the navigation sentence framer
// Behaviour
// - the line runs at 4800 baud, eight data bits, no parity and one stop bit.
// - the framer is the single driver of the line and any number of listeners may receive it.
// - every sentence starts with the dollar character.
// - the talker pair GP follows the start character.
// - a three-letter message identifier follows the talker pair.
// - each data field is preceded by exactly one comma.
// - an asterisk follows the last data field.
// - the checksum goes out as two hex characters, high nibble first.
// - carriage return then line feed end the sentence right after the checksum.
// - a sentence holds at most 79 characters, not counting the start character and the CR LF pair.
// - the data block with its commas holds at most 74 characters.
// - by default a fix sentence and a track and speed sentence go out once per second with talker GP and checksum.
`ifndef NSF_MAP_SVH
`define NSF_MAP_SVH
`define NSF_CLK_HZ 40000000
`define NSF_BAUD 4800
`define NSF_DATA_BITS 8
`define NSF_STOP_BITS 1
`define NSF_REPORT_S 1
`define NSF_SENT_MAX 79
`define NSF_FIELD_MAX 74
`define NSF_HEAD_LEN 5
`define NSF_TAIL_LEN 3
`define NSF_CH_DOLLAR 8'h24
`define NSF_CH_COMMA 8'h2C
`define NSF_CH_STAR 8'h2A
`define NSF_CH_CR 8'h0D
`define NSF_CH_LF 8'h0A
`define NSF_CH_TALK0 8'h47
`define NSF_CH_TALK1 8'h50
`define NSF_MSG_FIX 24'h474741
`define NSF_MSG_TRACK 24'h565447
`define NSF_FIFO_DEPTH 8
`define NSF_FIFO_WIDTH 10
`endif

// File: nsf_pkg.sv
// types of the navigation sentence framer
package nsf_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_DOLLAR, ST_TALK0, ST_TALK1, ST_MSG0, ST_MSG1, ST_MSG2,
        ST_FIELD, ST_STAR, ST_CSH, ST_CSL, ST_CR, ST_LF, ST_DRAIN
    } nsf_state_e;
    typedef logic [7:0] nsf_char_t;
endpackage : nsf_pkg

// File: nsf_framer.sv
// sentence framer with field fifo and serial transmitter
`timescale 1ns/1ps
`include "nsf_map.svh"

module nsf_fifo #(
    parameter int WIDTH = `NSF_FIFO_WIDTH,
    parameter int DEPTH = `NSF_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rd_reg];
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            in_ready <= 1'b1;
        end else if (ce) begin
            if (push) begin
                mem[wr_reg] <= in_data;
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_next;
            in_ready <= cnt_next != (AW+1)'(DEPTH);
        end
    end
endmodule : nsf_fifo

module nsf_framer #(
    parameter int BIT_CYC = `NSF_CLK_HZ / `NSF_BAUD,
    parameter int REPORT_CYC = `NSF_CLK_HZ * `NSF_REPORT_S
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic report_en,
    input wire logic fld_valid,
    output logic fld_ready,
    input wire logic [`NSF_FIFO_WIDTH-1:0] fld_data,
    output logic sched_req,
    output logic sched_track,
    output logic busy,
    output logic trunc,
    output logic tx_line
);
    localparam int DATA_LIM = `NSF_SENT_MAX - `NSF_HEAD_LEN - `NSF_TAIL_LEN;
    localparam int DATA_MAX = (DATA_LIM < `NSF_FIELD_MAX) ? DATA_LIM : `NSF_FIELD_MAX;
    localparam int FRAME_BITS = 1 + `NSF_DATA_BITS + `NSF_STOP_BITS;

    function automatic nsf_pkg::nsf_char_t hex_char(input logic [3:0] n);
        hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : hex_char

    nsf_pkg::nsf_state_e state_reg;
    nsf_pkg::nsf_state_e state_next;
    logic [1:0] pend_reg;
    logic [25:0] tick_cnt_reg;
    logic [23:0] msg_reg;
    logic [7:0] cs_reg;
    logic [6:0] data_cnt_reg;
    logic comma_done_reg;
    logic tx_busy_reg;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [13:0] baud_cnt_reg;
    nsf_pkg::nsf_char_t tx_char;

    logic f_valid;
    logic [`NSF_FIFO_WIDTH-1:0] f_word;
    logic f_pop;

    // field bytes: [9] last of sentence, [8] field start, [7:0] char or 00 for none
    nsf_fifo #(.WIDTH(`NSF_FIFO_WIDTH), .DEPTH(`NSF_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .in_valid(fld_valid),
        .in_ready(fld_ready),
        .in_data(fld_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_word)
    );

    wire tx_idle = !tx_busy_reg;
    wire tick = tick_cnt_reg == 26'(REPORT_CYC - 1);
    wire start = state_reg == nsf_pkg::ST_IDLE && report_en && pend_reg != 2'b00;
    wire fixed_st = state_reg != nsf_pkg::ST_IDLE && state_reg != nsf_pkg::ST_FIELD
        && state_reg != nsf_pkg::ST_DRAIN;
    wire fld_act = state_reg == nsf_pkg::ST_FIELD && tx_idle && f_valid;
    wire fld_comma = fld_act && f_word[8] && !comma_done_reg;
    wire fld_char = fld_act && !fld_comma;
    wire fld_room = data_cnt_reg < 7'(DATA_MAX);
    wire fld_send = (fld_comma || (fld_char && f_word[7:0] != 8'h00)) && fld_room;
    assign f_pop = fld_char;
    wire send = (fixed_st && tx_idle) || fld_send;
    wire cs_take = send && (state_reg inside {nsf_pkg::ST_TALK0, nsf_pkg::ST_TALK1, nsf_pkg::ST_MSG0,
        nsf_pkg::ST_MSG1, nsf_pkg::ST_MSG2, nsf_pkg::ST_FIELD});
    wire baud_end = baud_cnt_reg == 14'(BIT_CYC - 1);

    // character on offer in each state
    always_comb begin
        case (state_reg)
            nsf_pkg::ST_DOLLAR: tx_char = `NSF_CH_DOLLAR;
            nsf_pkg::ST_TALK0: tx_char = `NSF_CH_TALK0;
            nsf_pkg::ST_TALK1: tx_char = `NSF_CH_TALK1;
            nsf_pkg::ST_MSG0: tx_char = msg_reg[23:16];
            nsf_pkg::ST_MSG1: tx_char = msg_reg[15:8];
            nsf_pkg::ST_MSG2: tx_char = msg_reg[7:0];
            nsf_pkg::ST_FIELD: tx_char = fld_comma ? `NSF_CH_COMMA : f_word[7:0];
            nsf_pkg::ST_STAR: tx_char = `NSF_CH_STAR;
            nsf_pkg::ST_CSH: tx_char = hex_char(cs_reg[7:4]);
            nsf_pkg::ST_CSL: tx_char = hex_char(cs_reg[3:0]);
            nsf_pkg::ST_CR: tx_char = `NSF_CH_CR;
            nsf_pkg::ST_LF: tx_char = `NSF_CH_LF;
            default: tx_char = 8'h00;
        endcase
    end

    // sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            nsf_pkg::ST_IDLE: if (start) state_next = nsf_pkg::ST_DOLLAR;
            nsf_pkg::ST_FIELD: if (fld_char && f_word[9]) state_next = nsf_pkg::ST_STAR;
            nsf_pkg::ST_LF: if (tx_idle) state_next = nsf_pkg::ST_DRAIN;
            nsf_pkg::ST_DRAIN: if (tx_idle) state_next = nsf_pkg::ST_IDLE;
            default: if (fixed_st && tx_idle) state_next = nsf_pkg::nsf_state_e'(state_reg + 4'h1);
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= nsf_pkg::ST_IDLE;
            pend_reg <= 2'b00;
            tick_cnt_reg <= '0;
            msg_reg <= `NSF_MSG_FIX;
            cs_reg <= 8'h00;
            data_cnt_reg <= 7'h00;
            comma_done_reg <= 1'b0;
            sched_req <= 1'b0;
            sched_track <= 1'b0;
            busy <= 1'b0;
            trunc <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
            // pending set by the tick wins over the clear on start
            pend_reg <= (pend_reg & ~(start ? (pend_reg[0] ? 2'b01 : 2'b10) : 2'b00))
                | {tick && report_en, tick && report_en};
            sched_req <= start;
            busy <= state_next != nsf_pkg::ST_IDLE;
            if (start) begin
                msg_reg <= pend_reg[0] ? `NSF_MSG_FIX : `NSF_MSG_TRACK;
                sched_track <= !pend_reg[0];
                cs_reg <= 8'h00;
                data_cnt_reg <= 7'h00;
                comma_done_reg <= 1'b0;
                trunc <= 1'b0;
            end
            if (cs_take) cs_reg <= cs_reg ^ tx_char;
            if (fld_send) data_cnt_reg <= data_cnt_reg + 7'h01;
            if (fld_comma) comma_done_reg <= 1'b1;
            if (fld_char) comma_done_reg <= 1'b0;
            if ((fld_comma || (fld_char && f_word[7:0] != 8'h00)) && !fld_room) trunc <= 1'b1;
        end
    end

    // serial transmitter, lsb first, sole driver of the line
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_busy_reg <= 1'b0;
            shift_reg <= '1;
            bit_cnt_reg <= 4'h0;
            baud_cnt_reg <= '0;
            tx_line <= 1'b1;
        end else if (ce) begin
            if (send) begin
                shift_reg <= {1'b1, tx_char, 1'b0};
                tx_line <= 1'b0;
                tx_busy_reg <= 1'b1;
                bit_cnt_reg <= 4'h0;
                baud_cnt_reg <= '0;
            end else if (tx_busy_reg) begin
                baud_cnt_reg <= baud_end ? '0 : baud_cnt_reg + 1'b1;
                if (baud_end) begin
                    shift_reg <= {1'b1, shift_reg[FRAME_BITS-1:1]};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    tx_line <= (bit_cnt_reg == 4'(FRAME_BITS - 1)) ? 1'b1 : shift_reg[1];
                    if (bit_cnt_reg == 4'(FRAME_BITS - 1)) tx_busy_reg <= 1'b0;
                end
            end
        end
    end

    a_idle_line_high: assert property (@(posedge clk) disable iff (srst)
        !tx_busy_reg |-> tx_line) else $error("line not high while idle");
    a_start_bit_low: assert property (@(posedge clk) disable iff (srst)
        (ce && send) |=> !tx_line [*2]) else $error("start bit not held low");
    a_dollar_first: assert property (@(posedge clk) disable iff (srst)
        $past(state_reg) == nsf_pkg::ST_IDLE && state_reg == nsf_pkg::ST_DOLLAR |-> ##[0:1] send
        && tx_char == 8'h24) else $error("sentence did not open with dollar");
    a_talker_pair: assert property (@(posedge clk) disable iff (srst)
        send && state_reg == nsf_pkg::ST_TALK0 |-> tx_char == 8'h47) else $error("talker letter wrong");
    a_msg_ident: assert property (@(posedge clk) disable iff (srst)
        send && state_reg == nsf_pkg::ST_MSG2 |-> tx_char == (sched_track ? 8'h47 : 8'h41))
        else $error("message id wrong");
    a_field_comma: assert property (@(posedge clk) disable iff (srst)
        fld_send && fld_comma |-> tx_char == 8'h2C) else $error("field not led by comma");
    a_star_then_hex: assert property (@(posedge clk) disable iff (srst)
        ce && send && state_reg == nsf_pkg::ST_STAR |=> state_reg == nsf_pkg::ST_CSH)
        else $error("no checksum after star");
    a_hex_upper: assert property (@(posedge clk) disable iff (srst)
        send && state_reg inside {nsf_pkg::ST_CSH, nsf_pkg::ST_CSL}
        |-> tx_char inside {[8'h30:8'h39], [8'h41:8'h46]}) else $error("checksum digit not upper-case hex");
    a_crlf_order: assert property (@(posedge clk) disable iff (srst)
        ce && send && state_reg == nsf_pkg::ST_CR |=> state_reg == nsf_pkg::ST_LF) else $error("cr not followed by lf");
    a_data_limit: assert property (@(posedge clk) disable iff (srst)
        data_cnt_reg <= 7'(DATA_MAX)) else $error("data block too long");
    a_no_overlap: assert property (@(posedge clk) disable iff (srst)
        state_reg == nsf_pkg::ST_IDLE |-> !tx_busy_reg || $past(state_reg) == nsf_pkg::ST_IDLE)
        else $error("new sentence while line busy");
    a_tick_pending: assert property (@(posedge clk) disable iff (srst)
        ce && tick && report_en |=> pend_reg == 2'b11) else $error("tick did not queue both sentences");
    c_fix_sentence: cover property (@(posedge clk) sched_req && !sched_track);
    c_track_sentence: cover property (@(posedge clk) sched_req && sched_track);
    c_truncated: cover property (@(posedge clk) $rose(trunc));
    c_fifo_full: cover property (@(posedge clk) !fld_ready && fld_valid);
endmodule : nsf_framer

// File: nsf_listener.sv
// serial listener model for the sentence framer
`timescale 1ns/1ps
module nsf_listener #(
    parameter int BIT_CYC = 4
) (
    input wire logic clk,
    input wire logic line,
    output logic rx_valid,
    output nsf_pkg::nsf_char_t rx_char,
    output logic rx_ferr
);
    // only samples the line, never drives it
    initial begin
        rx_valid = 1'h0;
        rx_char = 8'h00;
        rx_ferr = 1'h0;
        forever begin
            @(posedge clk);
            rx_valid <= 1'h0;
            if (line === 1'h0) begin
                repeat (BIT_CYC / 2) @(posedge clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(posedge clk);
                    rx_char[i] <= line;
                end
                repeat (BIT_CYC) @(posedge clk);
                rx_ferr <= (line !== 1'h1);
                rx_valid <= 1'h1;
            end
        end
    end
endmodule : nsf_listener

// File: nsf_framer_tb.sv
// testbench of the sentence framer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module nsf_framer_tb;
    localparam int BIT_CYC = 4;
    localparam int REP_CYC = 2000;
    typedef struct {string txt; logic trk;} nsf_row_s;
    logic clk, srst, ce, report_en, fld_valid, fld_ready;
    logic sched_req, sched_track, busy, trunc, tx_line, rx_valid, rx_ferr;
    logic [9:0] fld_data;
    nsf_pkg::nsf_char_t rx_char;
    nsf_pkg::nsf_char_t rx_q[$];
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    int t_fix = 0;
    nsf_row_s rows[6];
    string hx = "0123456789ABCDEF";

    nsf_framer #(.BIT_CYC(BIT_CYC), .REPORT_CYC(REP_CYC)) nsf_framer_inst (.clk(clk), .srst(srst),
        .ce(ce), .report_en(report_en), .fld_valid(fld_valid), .fld_ready(fld_ready),
        .fld_data(fld_data), .sched_req(sched_req), .sched_track(sched_track), .busy(busy),
        .trunc(trunc), .tx_line(tx_line));
    nsf_listener #(.BIT_CYC(BIT_CYC)) nsf_listener_inst (.clk(clk), .line(tx_line),
        .rx_valid(rx_valid), .rx_char(rx_char), .rx_ferr(rx_ferr));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rx_valid) begin
            rx_q.push_back(rx_char);
            `CHK("stop_bit", 1'h0, rx_ferr)
        end
        if (cyc == 30000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic wait_req();
        int k = 0;
        while (sched_req !== 1'h1 && k < 9000) begin
            @(posedge clk);
            k++;
        end
    endtask : wait_req

    task automatic push(logic [9:0] w, logic full_exp);
        logic rdy;
        fld_valid <= 1'h1;
        fld_data <= w;
        do begin
            @(negedge clk);
            rdy = fld_ready;
            if (full_exp) `CHK("fifo_full", 1'h0, rdy)
            full_exp = 1'h0;
            @(posedge clk);
        end while (!rdy);
    endtask : push

    task automatic run_row(int r);
        string t, e;
        logic [9:0] wq[$];
        logic nf;
        int n;
        logic [7:0] cs;
        t = rows[r].txt;
        wait_req();
        rx_q.delete();
        `CHK("sched_track", rows[r].trk, sched_track)
        if (r == 0) t_fix = cyc;
        if (r == 2) `CHK("period", REP_CYC, cyc - t_fix)
        nf = 1'h0;
        foreach (t[i]) begin
            if (t[i] == "," && nf) wq.push_back(10'h100);
            if (t[i] != ",") wq.push_back({1'h0, nf, t[i]});
            nf = (t[i] == ",");
        end
        if (nf) wq.push_back(10'h100);
        foreach (wq[i]) push(wq[i] | ((i == wq.size() - 1) ? 10'h200 : 10'h000), i == 8);
        fld_valid <= 1'h0;
        n = 0;
        while ((rx_q.size() == 0 || rx_q[$] !== 8'h0A) && n < 9000) begin
            @(posedge clk);
            n++;
        end
        if (t.len() > 71) t = t.substr(0, 70);
        e = {"GP", rows[r].trk ? "VTG" : "GGA", t};
        cs = 8'h00;
        foreach (e[i]) cs ^= e[i];
        e = {"$", e, "*", hx.substr(cs[7:4], cs[7:4]), hx.substr(cs[3:0], cs[3:0]), "\015\012"};
        `CHK("length", e.len(), rx_q.size())
        for (int i = 0; i < e.len(); i++)
            `CHK("char", e[i], rx_q[i])
        n = 0;
        foreach (rx_q[i]) n += (rx_q[i] === 8'h2C);
        foreach (t[i]) n -= (t[i] == ",");
        `CHK("field_count", 0, n)
        `CHK("trunc", rows[r].txt.len() > 71, trunc)
        `CHK("fifo_empty", 1'h1, fld_ready)
    endtask : run_row

    initial begin
        srst = 1'h1;
        ce = 1'h1;
        report_en = 1'h0;
        fld_valid = 1'h0;
        fld_data = 10'h000;
        rows[0] = '{",1234,5678,9", 1'h0};
        rows[1] = '{",,054.7,T,,", 1'h1};
        rows[2] = '{",A,B,C,D,E,F", 1'h0};
        rows[3] = '{",X", 1'h1};
        rows[4] = '{"", 1'h0};
        repeat (8) rows[4].txt = {rows[4].txt, ",123456789"};
        rows[5] = '{",Z", 1'h0};
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        report_en <= 1'h1;
        @(posedge clk);
        `CHK("line_idle", 1'h1, tx_line)
        `CHK("ready_rst", 1'h1, fld_ready)
        `CHK("busy_rst", 1'h0, busy)
        `CHK("req_rst", 1'h0, sched_req)
        for (int r = 0; r < 6; r++) run_row(r);
        wait_req();
        repeat (60) @(posedge clk);
        srst <= 1'h1;
        @(posedge clk);
        srst <= 1'h0;
        t_fix = cyc;
        @(posedge clk);
        `CHK("busy_mid", 1'h0, busy)
        `CHK("line_mid", 1'h1, tx_line)
        ce <= 1'h0;
        repeat (100) @(posedge clk);
        ce <= 1'h1;
        wait_req();
        `CHK("ce_period", REP_CYC + 102, cyc - t_fix)
        finish_test();
    end
endmodule : nsf_framer_tb
